// File: include/eewts_defines.svh
/*
 * Constants of the two-wire EEPROM slave: address match, bit counts,
 * page geometry and program-cycle timing.
 * Assumes inclusion by bare name from any file that needs them.
 */
`ifndef EEWTS_DEFINES_SVH
`define EEWTS_DEFINES_SVH

`define EEWTS_DEV_ID      4'hA
`define EEWTS_BIT_ACK     4'h8
`define EEWTS_BIT_RDLAST  4'h7
`define EEWTS_ADDR_W      7
`define EEWTS_PAGE_W      4
`define EEWTS_PAGE_BYTES  16
`define EEWTS_MEM_BYTES   128
`define EEWTS_CNT_W       20
`define EEWTS_CLK_NS      8
`define EEWTS_TWR_NS      5000000

`endif

// File: include/eewts_pkg.sv
/*
 * Types of the two-wire EEPROM slave: protocol engine states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package eewts_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_WADDR,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_RACK,
    ST_WAITSTOP
  } eewts_state_t;

endpackage

// File: core/eewts_sync.sv
/*
 * Two-flop synchroniser, one lane per bit, for levels entering the
 * reference clock domain.
 * Assumes inputs are asynchronous levels; stage one is read by stage two
 * only.
 */
`timescale 1ns/10ps
`default_nettype none

module eewts_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  ////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : gLane
      logic meta;
      // two stages; only the second stage is visible
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta    <= 1'b0;
          dout[g] <= 1'b0;
        end else begin
          meta    <= din[g];
          dout[g] <= meta;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// File: core/eewts_top.sv
/*
 * Slave side of a two-wire serial EEPROM of 128 bytes, bi-directional
 * mode: START/STOP detection, address match, acknowledge, byte and page
 * write, self-timed program cycle, write protect and reads.
 * Assumes SCL at most a few MHz against ref_clk at 125 MHz; the SDA
 * wire level is resolved outside from sdaOe (open drain).
 */
// How it works
// - SDA edge with SCL high is decoded as START or STOP
// - transmit-only clock pin: only its level is used, as write enable
// - START is SDA falling with SCL high; nothing counts before it
// - STOP is SDA rising with SCL high and ends the transaction
// - slave address matches on upper nibble 1010, next three ignored
// - address lsb one means read, zero means write
// - acknowledge on match then read or write; silent on mismatch
// - receiver pulls SDA low for the whole ninth clock
// - in write, every received byte is acknowledged
// - read: send 8 bits, release, sample ack; no ack waits for STOP
// - pin must stay high during the write transfer to program
// - byte write: address, word address, data, STOP starts program
// - no answer at all during the program cycle
// - page write up to 16 bytes, only low address bits advance
// - beyond sixteen bytes the page position wraps and overwrites
// - STOP commits the whole page in one program cycle
// - ack polling: no ack while programming, ack once done
// - pin low makes the whole array read only
// - current address, random and sequential reads supported
// - address counter holds last accessed address plus one
// - counter wraps from 127 to 0
// - first SCL falling edge enters bi-directional mode until reset
// - program cycle lasts at most 5 ms from STOP
// - SDA is only pulled low or released
`timescale 1ns/10ps
`default_nettype none
`include "eewts_defines.svh"

module eewts_top #(
  parameter int PROG_CYCLES = `EEWTS_TWR_NS / `EEWTS_CLK_NS
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // two-wire link; SCL is also the link clock
  input  wire logic sclClk,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  // write-enable level pin
  input  wire logic txOnlyClk,
  // status
  output logic      modeBidir,
  output logic      progBusy
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  eewts_pkg::eewts_state_t state_r;
  eewts_pkg::eewts_state_t nextSt_r;
  logic                    linkMode_r;
  logic [2:0]              syncQ;
  logic                    sclS;
  logic                    sdaS;
  logic                    txOnlyS;
  logic                    sclP_r;
  logic                    sdaP_r;
  logic [3:0]              bitCnt_r;
  logic [7:0]              rxShift_r;
  logic [7:0]              txShift_r;
  logic [`EEWTS_ADDR_W-1:0] addr_r;
  logic                    sdaOe_r;
  logic                    ackOk_r;
  logic                    wpSeen_r;
  logic                    busy_r;
  logic [`EEWTS_CNT_W-1:0] progCnt_r;
  logic [`EEWTS_PAGE_BYTES-1:0] pageMask_r;
  logic [2:0]              pageBase_r;
  logic [7:0]              pageBuf [`EEWTS_PAGE_BYTES];
  logic [7:0]              mem [`EEWTS_MEM_BYTES];
  logic                    sclRise;
  logic                    sclFall;
  logic                    startEv;
  logic                    stopEv;
  logic                    rxState;
  logic                    byteDone;
  logic                    devMatch;
  logic                    pageWr;
  logic                    progStart;
  logic                    progDone;
  logic [7:0]              memQ;

  // lookup decode used by the rxState assignment
  function automatic logic isRx(input eewts_pkg::eewts_state_t s);
    isRx = (s == eewts_pkg::ST_DEVADDR) || (s == eewts_pkg::ST_WADDR) ||
           (s == eewts_pkg::ST_WDATA);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // link domain: the mode latch is the only state clocked by SCL itself;
  // it can only set, so a glitchy crossing just delays the switch
  always_ff @(negedge sclClk or posedge rst) begin
    if (rst) begin
      linkMode_r <= 1'b0;
    end else begin
      linkMode_r <= 1'b1;
    end
  end

  // every pin and the link-domain level crosses through two flops
  eewts_sync #(.W(3)) uSync (
    .clk  (ref_clk),
    .rst  (rst),
    .din  ({sclClk, sdaIn, txOnlyClk}),
    .dout (syncQ)
  );
  assign sclS    = syncQ[2];
  assign sdaS    = syncQ[1];
  assign txOnlyS = syncQ[0];

  eewts_sync #(.W(1)) uModeSync (
    .clk  (ref_clk),
    .rst  (rst),
    .din  (linkMode_r),
    .dout (modeBidir)
  );

  ////////////////////////////////////////////////////////////////////////
  // previous samples for edge and condition detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclP_r <= 1'b1;
      sdaP_r <= 1'b1;
    end else begin
      sclP_r <= sclS;
      sdaP_r <= sdaS;
    end
  end

  // SDA moving while SCL stays high is a bus condition, never data
  assign sclRise  = modeBidir && sclS && !sclP_r;
  assign sclFall  = modeBidir && !sclS && sclP_r;
  assign startEv  = modeBidir && sclS && sclP_r && sdaP_r && !sdaS;
  assign stopEv   = modeBidir && sclS && sclP_r && !sdaP_r && sdaS;
  assign rxState  = isRx(state_r);
  assign byteDone = rxState && sclFall && (bitCnt_r == `EEWTS_BIT_ACK);
  assign devMatch = (rxShift_r[7:4] == `EEWTS_DEV_ID) && !busy_r;
  assign pageWr   = byteDone && (state_r == eewts_pkg::ST_WDATA);
  assign memQ     = mem[addr_r];
  // programming needs data, an unbroken high pin and an idle array
  assign progStart = stopEv && (state_r == eewts_pkg::ST_WDATA) &&
                     (|pageMask_r) && !wpSeen_r && txOnlyS &&
                     !busy_r;
  assign progDone  = busy_r &&
                     (progCnt_r == `EEWTS_CNT_W'(PROG_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////
  // protocol engine
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r   <= eewts_pkg::ST_IDLE;
      nextSt_r  <= eewts_pkg::ST_IDLE;
      bitCnt_r  <= 4'h0;
      rxShift_r <= 8'h00;
      txShift_r <= 8'h00;
      addr_r    <= '0;
      sdaOe_r   <= 1'b0;
      ackOk_r   <= 1'b0;
    end else if (startEv) begin
      state_r  <= eewts_pkg::ST_DEVADDR;
      bitCnt_r <= 4'h0;
      sdaOe_r  <= 1'b0;
    end else if (stopEv) begin
      state_r  <= eewts_pkg::ST_IDLE;
      bitCnt_r <= 4'h0;
      sdaOe_r  <= 1'b0;
    end else begin
      case (state_r)
        eewts_pkg::ST_DEVADDR, eewts_pkg::ST_WADDR,
        eewts_pkg::ST_WDATA: begin
          if (sclRise && bitCnt_r != `EEWTS_BIT_ACK) begin
            rxShift_r <= {rxShift_r[6:0], sdaS};
            bitCnt_r  <= bitCnt_r + 4'h1;
          end
          if (byteDone) begin
            bitCnt_r <= 4'h0;
            state_r  <= eewts_pkg::ST_ACK;
            sdaOe_r  <= 1'b1;
            case (state_r)
              eewts_pkg::ST_DEVADDR: begin
                if (!devMatch) begin
                  state_r <= eewts_pkg::ST_IDLE;
                  sdaOe_r <= 1'b0;
                end
                nextSt_r <= rxShift_r[0] ? eewts_pkg::ST_RDATA
                                         : eewts_pkg::ST_WADDR;
              end
              eewts_pkg::ST_WADDR: begin
                addr_r   <= rxShift_r[`EEWTS_ADDR_W-1:0];
                nextSt_r <= eewts_pkg::ST_WDATA;
              end
              default: begin
                // only the in-page bits advance
                addr_r[`EEWTS_PAGE_W-1:0] <=
                  addr_r[`EEWTS_PAGE_W-1:0] + 4'h1;
                nextSt_r <= eewts_pkg::ST_WDATA;
              end
            endcase
          end
        end
        eewts_pkg::ST_ACK: begin
          // ack held through the whole ninth clock, freed on its fall
          if (sclFall) begin
            state_r <= nextSt_r;
            sdaOe_r <= 1'b0;
            if (nextSt_r == eewts_pkg::ST_RDATA) begin
              txShift_r <= memQ;
              sdaOe_r   <= !memQ[7];
              addr_r    <= addr_r + 7'h01;
            end
          end
        end
        eewts_pkg::ST_RDATA: begin
          if (sclFall) begin
            if (bitCnt_r == `EEWTS_BIT_RDLAST) begin
              state_r  <= eewts_pkg::ST_RACK;
              bitCnt_r <= 4'h0;
              sdaOe_r  <= 1'b0;
            end else begin
              txShift_r <= {txShift_r[6:0], 1'b0};
              sdaOe_r   <= !txShift_r[6];
              bitCnt_r  <= bitCnt_r + 4'h1;
            end
          end
        end
        eewts_pkg::ST_RACK: begin
          if (sclRise) begin
            ackOk_r <= !sdaS;
          end
          if (sclFall) begin
            if (ackOk_r) begin
              state_r   <= eewts_pkg::ST_RDATA;
              txShift_r <= memQ;
              sdaOe_r   <= !memQ[7];
              addr_r    <= addr_r + 7'h01;
            end else begin
              state_r <= eewts_pkg::ST_WAITSTOP;
            end
          end
        end
        default: begin
          sdaOe_r <= 1'b0; // idle and wait-stop: only a bus condition moves
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write-protect watch: a single low sample spoils the whole transfer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wpSeen_r <= 1'b0;
    end else if (startEv) begin
      wpSeen_r <= !txOnlyS;
    end else if (!txOnlyS) begin
      wpSeen_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // page buffer: later bytes replace earlier ones at the same position
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pageMask_r <= '0;
      pageBase_r <= 3'h0;
    end else if ((startEv && !busy_r) || progDone) begin // polling keeps it
      pageMask_r <= '0;
    end else if (pageWr) begin
      pageMask_r[addr_r[`EEWTS_PAGE_W-1:0]] <= 1'b1;
      pageBase_r <= addr_r[`EEWTS_ADDR_W-1:`EEWTS_PAGE_W];
    end
  end

  // data lanes need no reset; the mask says which are live
  always_ff @(posedge ref_clk) begin
    if (pageWr) begin
      pageBuf[addr_r[`EEWTS_PAGE_W-1:0]] <= rxShift_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // self-timed program cycle; the pin may drop once it runs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_r    <= 1'b0;
      progCnt_r <= '0;
    end else if (progStart) begin
      busy_r    <= 1'b1;
      progCnt_r <= '0;
    end else if (progDone) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      progCnt_r <= progCnt_r + `EEWTS_CNT_W'(1);
    end
  end

  // the whole page lands in the array in one cycle at the end
  always_ff @(posedge ref_clk) begin
    if (progDone) begin
      for (int i = 0; i < `EEWTS_PAGE_BYTES; i++) begin
        if (pageMask_r[i]) begin
          mem[{pageBase_r, 4'(i)}] <= pageBuf[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs: open drain only ever pulls low
  assign sdaOut   = 1'b0;
  assign sdaOe    = sdaOe_r;
  assign progBusy = busy_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence seqAddrDone;
    byteDone && state_r == eewts_pkg::ST_DEVADDR;
  endsequence
  sequence seqReadLoad;
    sclFall && state_r == eewts_pkg::ST_ACK &&
    nextSt_r == eewts_pkg::ST_RDATA;
  endsequence
  chk_start_clears: assert property (
    startEv |=> state_r == eewts_pkg::ST_DEVADDR && bitCnt_r == 4'h0)
    else $error("start did not restart address phase");
  chk_stop_idles: assert property (
    stopEv |=> state_r == eewts_pkg::ST_IDLE && !sdaOe)
    else $error("stop did not end transaction");
  chk_busy_noack: assert property (
    (seqAddrDone and busy_r) ##0 !startEv ##0 !stopEv |=> !sdaOe)
    else $error("acknowledge given while programming");
  chk_match_ack: assert property (
    seqAddrDone ##0 devMatch ##0 !startEv ##0 !stopEv
      |=> sdaOe && state_r == eewts_pkg::ST_ACK)
    else $error("matching address not acknowledged");
  chk_prog_bound: assert property (
    busy_r |-> progCnt_r < `EEWTS_CNT_W'(PROG_CYCLES))
    else $error("program cycle overran");
  chk_wp_blocks: assert property (
    stopEv && !txOnlyS && !busy_r |=> !busy_r)
    else $error("write started with protect pin low");
  chk_mode_sticky: assert property (
    modeBidir |=> modeBidir)
    else $error("left bi-directional mode");
  chk_rack_release: assert property (
    state_r == eewts_pkg::ST_RACK |-> !sdaOe)
    else $error("sda driven during master acknowledge");
  chk_read_wrap: assert property (
    seqReadLoad ##0 addr_r == 7'h7F ##0 !startEv ##0 !stopEv
      |=> addr_r == 7'h00)
    else $error("address counter did not wrap");
  chk_page_hold: assert property (
    pageWr && !startEv && !stopEv |=>
      addr_r[6:4] == $past(addr_r[6:4]))
    else $error("page bits moved during page write");

endmodule

`default_nettype wire

// File: sim/eewts_i2c_master.sv
/*
 * Behavioural two-wire bus master facing the EEPROM slave.
 * Assumes the bench resolves the open-drain wire with a pull-up and
 * feeds it back on sdaWire.
 */
`timescale 1ns/10ps
`default_nettype none

module eewts_i2c_master #(
  parameter int HALF_NS = 32 // 64 ns link period, a whole number of core cycles
) (
  // two-wire link, master side
  output var logic sclClk,
  output var logic sdaPull,
  input  wire logic sdaWire
);
  // scl stands still high outside frames, line released
  initial begin
    sclClk  = 1'b1;
    sdaPull = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // start or repeated start; entered with scl high on a free bus or scl low after a byte
  task automatic start_cond();
    sdaPull = 1'b0;
    #HALF_NS sclClk = 1'b1;
    #HALF_NS sdaPull = 1'b1;
    #HALF_NS sclClk = 1'b0;
  endtask

  // every operation is closed by a stop
  task automatic stop_cond();
    sdaPull = 1'b1;
    #HALF_NS sclClk = 1'b1;
    #HALF_NS sdaPull = 1'b0;
    #HALF_NS;
  endtask

  // msb first; data only moves while scl is low
  task automatic send_bits(input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      sdaPull = ~d[7-i];
      #HALF_NS sclClk = 1'b1;
      #HALF_NS sclClk = 1'b0;
    end
  endtask

  // byte plus ninth clock, sampling the slave's acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    send_bits(d, 8);
    sdaPull = 1'b0;
    #HALF_NS sclClk = 1'b1;
    ack = ~sdaWire;
    #HALF_NS sclClk = 1'b0;
  endtask

  // receive a byte, then acknowledge unless it is the last one
  task automatic recv_byte(input logic last, output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      #HALF_NS sclClk = 1'b1;
      d = {d[6:0], sdaWire};
      #HALF_NS sclClk = 1'b0;
    end
    sdaPull = ~last;
    #HALF_NS sclClk = 1'b1;
    #HALF_NS sclClk = 1'b0;
    if (!last) begin
      sdaPull = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// File: sim/tb_top.sv
/*
 * Self-checking bench of the two-wire EEPROM slave.
 * Assumes the program cycle is shortened to PROG ref_clk cycles.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam int PROG = 600;
  logic ref_clk;
  logic rst;
  logic txOnlyClk;
  logic sclClk;
  logic sdaPull;
  logic sdaWire;
  logic sdaOut;
  logic sdaOe;
  logic modeBidir;
  logic progBusy;
  int   error_cnt = 0;
  int   checked = 0;

  // open-drain wire with pull-up
  assign sdaWire = ~((sdaOe & ~sdaOut) | sdaPull);

  eewts_top #(.PROG_CYCLES(PROG)) u_dut (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .sclClk    (sclClk),
    .sdaIn     (sdaWire),
    .sdaOut    (sdaOut),
    .sdaOe     (sdaOe),
    .txOnlyClk (txOnlyClk),
    .modeBidir (modeBidir),
    .progBusy  (progBusy)
  );

  eewts_i2c_master u_mst (
    .sclClk  (sclClk),
    .sdaPull (sdaPull),
    .sdaWire (sdaWire)
  );

  // 125 MHz core clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d, mismatched %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] act, input logic [7:0] exp);
    checked++;
    if (act !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic cmp1(input logic act, input logic exp);
    cmp8({7'h00, act}, {7'h00, exp});
  endtask

  // byte with its expected acknowledge
  task automatic tx(input logic [7:0] d, input logic expAck);
    logic a;
    u_mst.send_byte(d, a);
    cmp1(a, expAck);
  endtask

  task automatic rd(input logic last, input logic [7:0] exp);
    logic [7:0] d;
    u_mst.recv_byte(last, d);
    cmp8(d, exp);
  endtask

  // level pin moves just after a core clock edge
  task automatic set_wp(input logic v);
    @(posedge ref_clk);
    #1 txOnlyClk = v;
  endtask

  // bounded wait for the end of the program cycle
  task automatic wait_idle();
    int n;
    n = 0;
    while (progBusy !== 1'b0 && n < 4 * PROG) begin
      @(posedge ref_clk);
      n++;
    end
    // step off the edge so the next bus move does not race the core clock
    #1;
    cmp1(n <= PROG, 1'b1);
    if (n >= 4 * PROG) begin
      error_cnt++;
      complete_run();
    end
  endtask

  // page 0 after 18 bytes: slots 0 and 1 overwritten by bytes 16, 17
  function automatic logic [7:0] page_exp(input int s);
    return (s < 2) ? 8'h50 + 8'(s) : 8'h40 + 8'(s);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // a start before the first scl fall is not seen
  task automatic t_mode();
    cmp1(modeBidir, 1'b0);
    u_mst.start_cond();
    u_mst.stop_cond();
    cmp1(modeBidir, 1'b1);
    cmp1(sdaOe, 1'b0);
    cmp1(sdaOut, 1'b0);
  endtask

  // byte write, then polling while busy with the pin dropped
  task automatic t_byte_write();
    u_mst.start_cond();
    tx(8'hA0, 1'b1);
    tx(8'hFF, 1'b1);
    tx(8'h3C, 1'b1);
    u_mst.stop_cond();
    cmp1(progBusy, 1'b1);
    set_wp(1'b0);
    u_mst.start_cond();
    tx(8'hA0, 1'b0);
    u_mst.stop_cond();
    wait_idle();
    set_wp(1'b1);
    u_mst.start_cond();
    tx(8'hAE, 1'b1);
    u_mst.stop_cond();
  endtask

  // eighteen bytes into page 0 wrap over slots 0 and 1
  task automatic t_page_write();
    u_mst.start_cond();
    tx(8'hA0, 1'b1);
    tx(8'h00, 1'b1);
    for (int i = 0; i < 18; i++) begin
      tx(8'h40 + 8'(i), 1'b1);
    end
    u_mst.stop_cond();
    cmp1(progBusy, 1'b1);
    wait_idle();
  endtask

  // random read across 127, sequential, then current address
  task automatic t_read_wrap();
    u_mst.start_cond();
    tx(8'hA0, 1'b1);
    tx(8'h7F, 1'b1);
    u_mst.start_cond();
    tx(8'hA1, 1'b1);
    rd(1'b0, 8'h3C);
    for (int i = 0; i < 15; i++) begin
      rd(i == 14, page_exp(i));
    end
    u_mst.stop_cond();
    u_mst.start_cond();
    tx(8'hA1, 1'b1);
    rd(1'b1, page_exp(15));
    u_mst.stop_cond();
  endtask

  // protected write, aborted byte and a foreign address change nothing
  task automatic t_protect_abort();
    set_wp(1'b0);
    u_mst.start_cond();
    tx(8'hA0, 1'b1);
    tx(8'h7F, 1'b1);
    tx(8'hA5, 1'b1);
    u_mst.stop_cond();
    cmp1(progBusy, 1'b0);
    set_wp(1'b1);
    u_mst.start_cond();
    tx(8'hA0, 1'b1);
    tx(8'h7F, 1'b1);
    u_mst.send_bits(8'hC3, 4);
    u_mst.stop_cond();
    cmp1(progBusy, 1'b0);
    u_mst.start_cond();
    tx(8'h90, 1'b0);
    u_mst.stop_cond();
    u_mst.start_cond();
    tx(8'hA0, 1'b1);
    tx(8'h7F, 1'b1);
    u_mst.start_cond();
    tx(8'hA1, 1'b1);
    rd(1'b1, 8'h3C);
    u_mst.stop_cond();
  endtask

  // reset for four cycles, then the scenarios in order
  initial begin
    rst = 1'b1;
    txOnlyClk = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    t_mode();
    t_byte_write();
    t_page_write();
    t_read_wrap();
    t_protect_abort();
    complete_run();
  end
endmodule

`default_nettype wire
